// ===== design/asp_top.sv
// async serial port: Avalon-MM registers, tx/rx framers, receive fifo
// assumes rxd_i is asynchronous to clock_i; waitrequest gives one wait cycle
// ****************************************
// Operation
// R01 - writes to the data location load the transmitter and reads return the receive fifo head.
// R02 - up to three received bytes are held before any is lost.
// R03 - tx done and rx ready flags are set by hardware and raise the interrupt when enabled.
// R04 - hardware never clears the flags; software clears them by writing zero.
// R05 - a software clear of rx ready is ignored while the receive fifo holds bytes.
// R06 - the baud timer is 16 bits, fed from the core clock through a 1/4/12/48 prescaler.
// R07 - nothing is sent or received while the baud generator is disabled.
// R08 - the baud timer counts up from the reload value and reloads on wrap.
// R09 - software should keep the baud rate at or below a sixteenth of the core clock.
// R10 - frames are start low, data lsb first, optional ninth bit, one or two stop high.
// R11 - data length is selectable from five to eight bits.
// R12 - parity is generated and checked as even, odd, mark or space.
// R13 - the extra bit is ignored while parity is enabled.
// R14 - two stop bits apply only to six, seven or eight data bits.
// R15 - a multiprocessor mode keeps only frames whose ninth bit is set.
// R16 - one bit lasts sixteen timer wraps and receive samples mid-bit.
// R17 - a byte arriving with the fifo full is dropped and flags overrun.
module asp_top
   import asp_pkg::*;
#(
   parameter int DEPTH = 3
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic [5:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   output logic [31:0] readdata_o,
   output logic waitrequest_o,
   input wire logic rxd_i,
   output logic txd_o,
   output logic irq_o
);
   // ****************************************
   // helpers
   // ****************************************
   // parity bit of the selected type (even, odd, mark or space) over the active data bits
   function automatic logic par_of(input logic [7:0] d, input logic [1:0] len,
                                   input logic [1:0] ptype);
      logic [7:0] m;
      logic p;
      m = 8'hff >> (2'h3 - len);
      p = ^(d & m);
      case (ptype)
         PAR_EVEN: par_of = p;
         PAR_ODD: par_of = ~p;
         PAR_MARK: par_of = 1'b1;
         default: par_of = 1'b0;
      endcase
   endfunction

   function automatic logic [1:0] ptr_inc(input logic [1:0] p);
      ptr_inc = (p == 2'(DEPTH - 1)) ? 2'h0 : p + 2'h1;
   endfunction

   // ****************************************
   // declarations
   // ****************************************
   logic [FMT_W-1:0] fmt;
   logic [3:0] bcon;
   logic [15:0] reload;
   logic rx_en;
   logic rx_rdy;
   logic tx_done;
   logic ovr;
   logic perr;
   logic ferr;
   logic [IRQ_W-1:0] istat;
   logic [IRQ_W-1:0] ien;
   logic tick;
   logic acc;
   logic wr_acc;
   logic rd_acc;
   logic [8:0] fifo [0:DEPTH-1];
   logic [1:0] wptr;
   logic [1:0] rptr;
   logic [1:0] count;
   logic push;
   logic pop;
   logic ovr_evt;
   logic tx_evt;
   logic [8:0] rx_word;
   asp_state_e tx_st;
   logic [3:0] tx_ovs;
   logic [2:0] tx_bit;
   logic [7:0] tx_sh;
   logic tx_b9;
   logic tx_stop2;
   asp_state_e rx_st;
   logic [3:0] rx_ovs;
   logic [2:0] rx_bit;
   logic [7:0] rx_sh;
   logic rx_b9;
   logic [2:0] rx_sync;
   logic rx_lvl;
   logic ninth_en;
   logic stop2_ok;
   logic [2:0] last_bit;

   // ****************************************
   // format decode
   // ****************************************
   // extra bit only counts without parity [R13]; 5-bit frames get one stop [R14]
   assign ninth_en = fmt[FMT_PEN] || fmt[FMT_XBE]; // [R13]
   assign stop2_ok = fmt[FMT_STOP2] && (fmt[FMT_LEN+:2] != LEN_5); // [R14]
   assign last_bit = 3'(LEN_BASE + 4'(fmt[FMT_LEN+:2]) - 4'h1); // [R11]

   // ****************************************
   // Avalon-MM slave
   // ****************************************
   // a request is acted on at the edge where waitrequest is seen low
   assign acc = (read_i || write_i) && !waitrequest_o;
   assign wr_acc = write_i && !waitrequest_o;
   assign rd_acc = read_i && !waitrequest_o;
   assign pop = rd_acc && (address_i == ADDR_DATA) && (count != 2'h0); // [R01]

   // one wait cycle per access, then release for one cycle
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         waitrequest_o <= 1'b1;
      end else begin
         waitrequest_o <= !((read_i || write_i) && waitrequest_o);
      end
   end

   // read data prepared in the wait cycle; transmit data is never readable [R01]
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         readdata_o <= '0;
      end else if (read_i && waitrequest_o) begin
         case (address_i)
            ADDR_DATA: readdata_o <= {24'h0, fifo[rptr][7:0]}; // [R01]
            ADDR_CTRL: readdata_o <= {24'h0, ferr, perr, fifo[rptr][8],
                                      (tx_st != ST_IDLE), ovr, rx_en, tx_done, rx_rdy};
            ADDR_FMT: readdata_o <= {23'h0, fmt};
            ADDR_BCON: readdata_o <= {28'h0, bcon};
            ADDR_RLL: readdata_o <= {24'h0, reload[7:0]};
            ADDR_RLH: readdata_o <= {24'h0, reload[15:8]};
            ADDR_ISTAT: readdata_o <= {29'h0, istat};
            ADDR_IEN: readdata_o <= {29'h0, ien};
            default: readdata_o <= '0;
         endcase
      end
   end

   // configuration registers
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         fmt <= FMT_RESET;
         bcon <= '0;
         reload <= '0;
         rx_en <= 1'b0;
         ien <= '0;
      end else if (wr_acc) begin
         case (address_i)
            ADDR_FMT: fmt <= writedata_i[FMT_W-1:0];
            ADDR_BCON: bcon <= writedata_i[3:0];
            ADDR_RLL: reload[7:0] <= writedata_i[7:0];
            ADDR_RLH: reload[15:8] <= writedata_i[7:0];
            ADDR_CTRL: rx_en <= writedata_i[CTL_RXEN];
            ADDR_IEN: ien <= writedata_i[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // ****************************************
   // baud rate generator
   // ****************************************
   asp_baud_gen #(.W(16)) u_baud (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .en_i(bcon[BCON_EN]),
      .src_i(bcon[BCON_SRC]),
      .ps_sel_i(bcon[BCON_PS+:2]),
      .reload_i(reload),
      .tick_o(tick)
   );

   // ****************************************
   // transmitter
   // ****************************************
   // a write while busy is dropped: there is no transmit holding register
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_st <= ST_IDLE;
         tx_ovs <= '0;
         tx_bit <= '0;
         tx_sh <= '0;
         tx_b9 <= 1'b0;
         tx_stop2 <= 1'b0;
         txd_o <= 1'b1;
      end else if (!bcon[BCON_EN]) begin
         tx_st <= ST_IDLE; // [R07]
         txd_o <= 1'b1;
      end else begin
         case (tx_st)
            ST_IDLE: begin
               if (wr_acc && address_i == ADDR_DATA) begin
                  tx_sh <= writedata_i[7:0]; // [R01]
                  tx_b9 <= fmt[FMT_PEN] ? par_of(writedata_i[7:0], fmt[FMT_LEN+:2],
                                                 fmt[FMT_PTYPE+:2]) : fmt[FMT_TXB9]; // [R12]
                  tx_stop2 <= stop2_ok;
                  tx_ovs <= '0;
                  tx_st <= ST_START;
                  txd_o <= 1'b0; // [R10]
               end
            end
            default: begin
               if (tick) begin
                  tx_ovs <= tx_ovs + 4'h1;
                  if (tx_ovs == OVS_LAST) begin // [R16]
                     case (tx_st)
                        ST_START: begin
                           tx_st <= ST_DATA;
                           tx_bit <= '0;
                           txd_o <= tx_sh[0]; // [R10]
                        end
                        ST_DATA: begin
                           tx_sh <= tx_sh >> 1;
                           tx_bit <= tx_bit + 3'h1;
                           if (tx_bit != last_bit) begin
                              txd_o <= tx_sh[1];
                           end else if (ninth_en) begin
                              tx_st <= ST_NINTH;
                              txd_o <= tx_b9;
                           end else begin
                              tx_st <= ST_STOP;
                              txd_o <= 1'b1;
                           end
                        end
                        ST_NINTH: begin
                           tx_st <= ST_STOP;
                           txd_o <= 1'b1;
                        end
                        default: begin
                           if (tx_stop2) begin
                              tx_stop2 <= 1'b0; // [R14]
                           end else begin
                              tx_st <= ST_IDLE;
                           end
                        end
                     endcase
                  end
               end
            end
         endcase
      end
   end

   // done is flagged as the first stop bit begins
   assign tx_evt = bcon[BCON_EN] && tick && (tx_ovs == OVS_LAST) && (tx_st == ST_NINTH ||
                   (tx_st == ST_DATA && tx_bit == last_bit && !ninth_en)); // [R03]

   // ****************************************
   // receiver
   // ****************************************
   // three-stage synchroniser; a level counts once stages two and three agree
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_sync <= 3'h7;
         rx_lvl <= 1'b1;
      end else begin
         rx_sync <= {rx_sync[1:0], rxd_i};
         if (rx_sync[1] == rx_sync[2]) begin
            rx_lvl <= rx_sync[2];
         end
      end
   end

   assign rx_word = {rx_b9, rx_sh >> (3'h7 - last_bit)};
   // keep the word only if mp mode is off or its ninth bit is set [R15]
   assign push = (rx_st == ST_STOP) && tick && (rx_ovs == OVS_LAST) && rx_lvl
                 && (!fmt[FMT_MCE] || (ninth_en && rx_b9)) && (count != 2'(DEPTH)); // [R02]
   assign ovr_evt = (rx_st == ST_STOP) && tick && (rx_ovs == OVS_LAST) && rx_lvl
                    && (!fmt[FMT_MCE] || (ninth_en && rx_b9))
                    && (count == 2'(DEPTH)); // [R17]

   // start is checked mid-bit, later bits one bit time apart
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_st <= ST_IDLE;
         rx_ovs <= '0;
         rx_bit <= '0;
         rx_sh <= '0;
         rx_b9 <= 1'b0;
      end else if (!bcon[BCON_EN] || !rx_en) begin
         rx_st <= ST_IDLE; // [R07]
      end else begin
         case (rx_st)
            ST_IDLE: begin
               if (!rx_lvl) begin
                  rx_st <= ST_START;
                  rx_ovs <= '0;
               end
            end
            ST_START: begin
               if (tick) begin
                  rx_ovs <= rx_ovs + 4'h1;
                  if (rx_ovs == OVS_MID) begin // [R16]
                     rx_ovs <= '0;
                     rx_bit <= '0;
                     rx_st <= rx_lvl ? ST_IDLE : ST_DATA;
                  end
               end
            end
            default: begin
               if (tick) begin
                  rx_ovs <= rx_ovs + 4'h1;
                  if (rx_ovs == OVS_LAST) begin
                     case (rx_st)
                        ST_DATA: begin
                           rx_sh <= {rx_lvl, rx_sh[7:1]}; // [R10]
                           rx_bit <= rx_bit + 3'h1;
                           if (rx_bit == last_bit) begin
                              rx_st <= ninth_en ? ST_NINTH : ST_STOP;
                           end
                        end
                        ST_NINTH: begin
                           rx_b9 <= rx_lvl;
                           rx_st <= ST_STOP;
                        end
                        default: rx_st <= ST_IDLE;
                     endcase
                  end
               end
            end
         endcase
      end
   end

   // ****************************************
   // receive fifo
   // ****************************************
   always_ff @(posedge clock_i) begin
      if (push) begin
         fifo[wptr] <= {fmt[FMT_XBE] && !fmt[FMT_PEN] && rx_b9, rx_word[7:0]}; // [R02]
      end
   end

   // a full fifo drops the new word and keeps the old ones [R17]
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wptr <= '0;
         rptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wptr <= ptr_inc(wptr);
         end
         if (pop) begin
            rptr <= ptr_inc(rptr);
         end
         count <= count + 2'(push) - 2'(pop);
      end
   end

   // ****************************************
   // status flags
   // ****************************************
   // software clears by writing zero; hardware set wins over the clear [R04]
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_rdy <= 1'b0;
         tx_done <= 1'b0;
         ovr <= 1'b0;
         perr <= 1'b0;
         ferr <= 1'b0;
      end else begin
         if (wr_acc && address_i == ADDR_CTRL) begin
            if (!writedata_i[CTL_RXRDY] && count == 2'h0) begin
               rx_rdy <= 1'b0; // [R05]
            end
            if (!writedata_i[CTL_TXDONE]) begin
               tx_done <= 1'b0; // [R04]
            end
            if (!writedata_i[CTL_OVR]) begin
               ovr <= 1'b0;
            end
            if (!writedata_i[CTL_PERR]) begin
               perr <= 1'b0;
            end
            if (!writedata_i[CTL_FERR]) begin
               ferr <= 1'b0;
            end
         end
         if (push) begin
            rx_rdy <= 1'b1; // [R03]
            if (fmt[FMT_PEN] && rx_b9 != par_of(rx_word[7:0], fmt[FMT_LEN+:2],
                                                fmt[FMT_PTYPE+:2])) begin
               perr <= 1'b1; // [R12]
            end
         end
         if (tx_evt) begin
            tx_done <= 1'b1; // [R03]
         end
         if (ovr_evt) begin
            ovr <= 1'b1; // [R17]
         end
         if (rx_st == ST_STOP && tick && rx_ovs == OVS_LAST && !rx_lvl) begin
            ferr <= 1'b1;
         end
      end
   end

   // ****************************************
   // interrupts
   // ****************************************
   // sticky events; a write of one clears, a same-cycle event wins
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         istat <= '0;
         irq_o <= 1'b0;
      end else begin
         istat <= (istat & ~((wr_acc && address_i == ADDR_ICLR) ?
                   writedata_i[IRQ_W-1:0] : {IRQ_W{1'b0}}))
                  | {ovr_evt, push, tx_evt}; // [R03]
         irq_o <= |(istat & ien); // [R03]
      end
   end
endmodule

// ===== design/asp_pkg.sv
// constants, register map and types of the async serial port
// assumes a single 100 MHz core clock and an Avalon-MM register slave
package asp_pkg;
   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [5:0] ADDR_DATA = 6'h00;
   localparam logic [5:0] ADDR_CTRL = 6'h04;
   localparam logic [5:0] ADDR_FMT = 6'h08;
   localparam logic [5:0] ADDR_BCON = 6'h0c;
   localparam logic [5:0] ADDR_RLL = 6'h10;
   localparam logic [5:0] ADDR_RLH = 6'h14;
   localparam logic [5:0] ADDR_ISTAT = 6'h18;
   localparam logic [5:0] ADDR_ICLR = 6'h1c;
   localparam logic [5:0] ADDR_IEN = 6'h20;

   // ****************************************
   // serial control fields
   // ****************************************
   localparam int CTL_RXRDY = 0;
   localparam int CTL_TXDONE = 1;
   localparam int CTL_RXEN = 2;
   localparam int CTL_OVR = 3;
   localparam int CTL_TXBUSY = 4;
   localparam int CTL_RXB9 = 5;
   localparam int CTL_PERR = 6;
   localparam int CTL_FERR = 7;

   // ****************************************
   // frame format fields
   // ****************************************
   localparam int FMT_W = 9;
   localparam int FMT_LEN = 0;
   localparam int FMT_PEN = 2;
   localparam int FMT_PTYPE = 3;
   localparam int FMT_XBE = 5;
   localparam int FMT_STOP2 = 6;
   localparam int FMT_MCE = 7;
   localparam int FMT_TXB9 = 8;
   localparam logic [FMT_W-1:0] FMT_RESET = 9'h003;
   localparam logic [1:0] LEN_5 = 2'h0;
   localparam logic [3:0] LEN_BASE = 4'h5;

   // ****************************************
   // baud generator control fields
   // ****************************************
   localparam int BCON_EN = 0;
   localparam int BCON_SRC = 1;
   localparam int BCON_PS = 2;
   localparam logic [5:0] PS_DIV1 = 6'h01;
   localparam logic [5:0] PS_DIV4 = 6'h04;
   localparam logic [5:0] PS_DIV12 = 6'h0c;
   localparam logic [5:0] PS_DIV48 = 6'h30;
   localparam logic [15:0] TMR_TOP = 16'hffff;

   // ****************************************
   // interrupt status bits and timing
   // ****************************************
   localparam int IRQ_TX = 0;
   localparam int IRQ_RX = 1;
   localparam int IRQ_OVR = 2;
   localparam int IRQ_W = 3;
   localparam logic [3:0] OVS_LAST = 4'hf;
   localparam logic [3:0] OVS_MID = 4'h7;

   typedef enum logic [1:0] {PAR_EVEN, PAR_ODD, PAR_MARK, PAR_SPACE} asp_par_e;
   typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_NINTH, ST_STOP} asp_state_e;
endpackage

// ===== design/asp_baud_gen.sv
// baud rate generator: prescaler plus 16-bit up-counting reload timer
// assumes enable, selects and reload come from flops on the same clock
module asp_baud_gen
   import asp_pkg::*;
#(
   parameter int W = 16
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic en_i,
   input wire logic src_i,
   input wire logic [1:0] ps_sel_i,
   input wire logic [W-1:0] reload_i,
   output logic tick_o
);
   // ****************************************
   // prescaler
   // ****************************************
   logic [5:0] pcnt;
   logic [5:0] plim;
   logic pre_tick;
   logic [W-1:0] tmr;

   always_comb begin
      case (ps_sel_i)
         2'h0: plim = PS_DIV1;
         2'h1: plim = PS_DIV4;
         2'h2: plim = PS_DIV12;
         default: plim = PS_DIV48;
      endcase
   end

   // src high bypasses the prescaler and ticks on every core clock [R06]
   assign pre_tick = en_i && (src_i || (pcnt == plim - 6'h01));

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pcnt <= '0;
      end else if (!en_i || pre_tick) begin
         pcnt <= '0;
      end else begin
         pcnt <= pcnt + 6'h01;
      end
   end

   // ****************************************
   // reload timer
   // ****************************************
   // counts up from reload, reloads on the wrap past all ones [R08]
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tmr <= '0;
         tick_o <= 1'b0;
      end else if (!en_i) begin
         tmr <= reload_i;
         tick_o <= 1'b0;
      end else begin
         tick_o <= pre_tick && (tmr == TMR_TOP[W-1:0]);
         if (pre_tick) begin
            tmr <= (tmr == TMR_TOP[W-1:0]) ? reload_i : tmr + 1'b1; // [R08]
         end
      end
   end
endmodule

// ===== sim/asp_top_sva.sv
// port checker for the async serial port top
// assumes one core clock and an active-low asynchronous reset
module asp_chk (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic [5:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   input wire logic [31:0] readdata_o,
   input wire logic waitrequest_o,
   input wire logic rxd_i,
   input wire logic txd_o,
   input wire logic irq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************
   // bus and line properties
   // ****************
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   wait_one_a: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
      else $error("request not answered after one wait cycle");
   wait_pulse_a: assert property (!waitrequest_o |=> waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   idle_wait_a: assert property (!read_i && !write_i |=> waitrequest_o)
      else $error("waitrequest low without a request");
   unmapped_rd_a: assert property (read_i && !waitrequest_o && address_i > 6'h20 |->
      readdata_o == 32'h0) else $error("unmapped read not zero");
   rd_hold_a: assert property (!(read_i && waitrequest_o) |=> $stable(readdata_o))
      else $error("read data moved without a read");
   rst_vals_a: assert property ($rose(rst_b_i) |-> waitrequest_o && txd_o && !irq_o)
      else $error("outputs not idle after reset");
   // a bit spans at least 16 core clocks, since a tick is never faster than one clock
   tx_start_a: assert property ($fell(txd_o) |=> !txd_o [*8])
      else $error("start bit too short");
   bit_len_a: assert property ($changed(txd_o) |=> $stable(txd_o) [*7])
      else $error("serial bit too short");
endmodule

bind asp_top asp_chk i_asp_chk (
   .clock_i(clock_i), .rst_b_i(rst_b_i), .address_i(address_i), .read_i(read_i),
   .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
   .waitrequest_o(waitrequest_o), .rxd_i(rxd_i), .txd_o(txd_o), .irq_o(irq_o)
);

// ===== sim/asp_remote.sv
// remote serial station on the shared rx and tx lines
// assumes one bit lasts 16 core clocks (direct clock, reload all ones)
module asp_remote (
   input wire logic clock_i,
   input wire logic txd_i,
   output logic rxd_o
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BIT = 16; // no faster than a sixteenth of the core clock
   // ****************
   // line driver and sampler
   // ****************
   // idle high between frames
   initial rxd_o = 1'b1;
   // start low, then n bits lsb first; caller ends with stop bits, so line rests high
   task automatic send(input logic [11:0] b, input int n);
      rxd_o <= 1'b0;
      repeat (BIT) @(posedge clock_i);
      for (int i = 0; i < n; i++) begin
         rxd_o <= b[i];
         repeat (BIT) @(posedge clock_i);
      end
   endtask
   // mid-bit sampling, returns after the first stop sample
   task automatic recv(input int n, output logic [11:0] b);
      b = 12'hfff;
      while (txd_i !== 1'b0) @(posedge clock_i);
      repeat (BIT / 2) @(posedge clock_i);
      for (int i = 0; i < n; i++) begin
         repeat (BIT) @(posedge clock_i);
         b[i] = txd_i;
      end
   endtask
endmodule

// ===== sim/testbench.sv
// self-checking bench for the async serial port
// assumes the remote model is the only party on the serial lines
module testbench import asp_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock_i = 1'b0, rst_b_i = 1'b0, read_i = 1'b0, write_i = 1'b0, rxd, irq_o;
   logic [5:0] address_i = 6'h0;
   logic [31:0] writedata_i = 32'h0, readdata_o, q;
   logic waitrequest_o, txd_o, p, nb;
   logic [8:0] f;
   logic [7:0] d;
   logic [11:0] e, g;
   logic [8:0] fmts [6] = '{9'h040, 9'h005, 9'h04e, 9'h13f, 9'h057, 9'h123};
   int errors = 0, cmp_count = 0, cyc = 0, len;
   always #5 clock_i = ~clock_i;
   asp_top #(.DEPTH(3)) i_asp_top (.clock_i(clock_i), .rst_b_i(rst_b_i),
      .address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
      .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .rxd_i(rxd), .txd_o(txd_o),
      .irq_o(irq_o));
   asp_remote i_asp_remote (.clock_i(clock_i), .txd_i(txd_o), .rxd_o(rxd));
   // ****************
   // tasks
   // ****************
   task automatic close_out();
      if (errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] x, input logic [31:0] y);
      cmp_count++;
      if (y !== x) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", s, x, y);
      end
   endtask
   // one access held until waitrequest is seen low, then a free edge
   task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] v);
      address_i <= a;
      write_i <= w;
      read_i <= !w;
      writedata_i <= v;
      do begin
         @(posedge clock_i);
      end while (waitrequest_o !== 1'b0);
      q = readdata_o;
      read_i <= 1'b0;
      write_i <= 1'b0;
      @(posedge clock_i);
   endtask
   task automatic rdc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] x,
      input string s);
      bus(a, 1'b0, 32'h0);
      chk(s, x, q & m);
   endtask
   // irq settles one edge after the register it follows
   task automatic irqc(input logic x);
      @(posedge clock_i);
      chk("irq", 32'(x), 32'(irq_o));
   endtask
   // hang guard, well above the few thousand cycles needed
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         close_out();
      end
   end
   // ****************
   // main sequence
   // ****************
   initial begin
      repeat (5) @(posedge clock_i);
      rst_b_i <= 1'b1;
      @(posedge clock_i);
      rdc(ADDR_FMT, 32'h1ff, 32'(FMT_RESET), "fmt");
      rdc(6'h3c, 32'hffffffff, 32'h0, "unmapped");
      bus(ADDR_RLL, 1'b1, 32'hff);
      bus(ADDR_RLH, 1'b1, 32'hff);
      bus(ADDR_IEN, 1'b1, 32'h1);
      bus(ADDR_DATA, 1'b1, 32'h55);
      for (int k = 0; k < 60; k++) begin
         @(posedge clock_i);
         chk("txd_idle", 32'h1, 32'(txd_o));
      end
      rdc(ADDR_ISTAT, 32'h7, 32'h0, "istat_off");
      bus(ADDR_BCON, 1'b1, 32'h3);
      repeat (300) @(posedge clock_i);
      bus(ADDR_CTRL, 1'b1, 32'h0);
      bus(ADDR_ICLR, 1'b1, 32'h7);
      // every length, parity type and stop choice on transmit
      for (int i = 0; i < 6; i++) begin
         f = fmts[i];
         len = f[1:0] + 5;
         d = (8'h9d + 8'(i * 53)) & ~(8'hff << len);
         nb = f[2] | f[5];
         p = !f[2] ? f[8] : f[4] ? !f[3] : f[3] ^ (^d);
         e = (12'hfff << len) | 12'(d);
         if (nb) e[len] = p;
         bus(ADDR_FMT, 1'b1, 32'(f));
         bus(ADDR_DATA, 1'b1, 32'(d));
         i_asp_remote.recv(len + nb + 1, g);
         chk("tx_frame", 32'(e), 32'(g));
         repeat (16) @(posedge clock_i);
         rdc(ADDR_CTRL, 32'h12, 32'h2 | 32'(f[6] && f[1:0] != LEN_5) << 4, "ctrl_tx");
         repeat (24) @(posedge clock_i);
         bus(ADDR_CTRL, 1'b1, 32'h0);
      end
      irqc(1'b1);
      bus(ADDR_IEN, 1'b1, 32'h0);
      irqc(1'b0);
      bus(ADDR_IEN, 1'b1, 32'h1);
      irqc(1'b1);
      bus(ADDR_ICLR, 1'b1, 32'h1);
      irqc(1'b0);
      // four bytes into a three-deep fifo
      bus(ADDR_FMT, 1'b1, 32'h003);
      bus(ADDR_CTRL, 1'b1, 32'h4);
      bus(ADDR_IEN, 1'b1, 32'h6);
      for (int k = 0; k < 4; k++) i_asp_remote.send({4'hf, 8'(8'ha1 + k * 17)}, 9);
      repeat (20) @(posedge clock_i);
      rdc(ADDR_CTRL, 32'h9, 32'h9, "ctrl_ovr");
      irqc(1'b1);
      bus(ADDR_CTRL, 1'b1, 32'h4);
      rdc(ADDR_CTRL, 32'h1, 32'h1, "rx_keep");
      for (int k = 0; k < 3; k++) rdc(ADDR_DATA, 32'hff, 32'(8'ha1 + k * 17), "rx");
      bus(ADDR_CTRL, 1'b1, 32'h4);
      rdc(ADDR_CTRL, 32'h1, 32'h0, "rx_clr");
      rdc(ADDR_ISTAT, 32'h6, 32'h6, "istat_rx");
      // wrong even parity on receive
      bus(ADDR_FMT, 1'b1, 32'h007);
      i_asp_remote.send(12'h201, 10);
      rdc(ADDR_CTRL, 32'h41, 32'h41, "perr");
      rdc(ADDR_DATA, 32'hff, 32'h1, "rx_par");
      bus(ADDR_CTRL, 1'b1, 32'h4);
      // multiprocessor: only frames with the ninth bit set are kept
      bus(ADDR_FMT, 1'b1, 32'h0a3);
      i_asp_remote.send(12'h233, 10);
      rdc(ADDR_CTRL, 32'h1, 32'h0, "mp_drop");
      i_asp_remote.send(12'h344, 10);
      rdc(ADDR_CTRL, 32'h21, 32'h21, "mp_keep");
      rdc(ADDR_DATA, 32'hff, 32'h44, "mp_data");
      // prescaled source: a bit is 16 wraps of 4 clocks times (65536 - 0xfffe)
      bus(ADDR_RLL, 1'b1, 32'hfe);
      bus(ADDR_BCON, 1'b1, 32'h5);
      bus(ADDR_DATA, 1'b1, 32'h1);
      while (txd_o !== 1'b1) @(posedge clock_i);
      len = 0;
      while (txd_o !== 1'b0) begin
         @(posedge clock_i);
         len++;
      end
      chk("bit_time", 32'd128, 32'(len));
      close_out();
   end
endmodule
